// ==== rtl/bfc_bus_feature_config.sv ====
// Bus feature configuration vector, masks and feature gating
`timescale 1ns/1ps
module bfc_bus_feature_config
    import bfc_pkg::*;
#(
    parameter logic [63:0] AVAIL_MASK = BFC_AVAIL_RST,
    parameter logic [63:0] CTRL_MASK = BFC_CTRL_RST,
    parameter logic [63:0] GROUP_MASK = BFC_GROUPS_RST
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // Strap pins caught at reset release
    input wire logic [63:0] strap_ctrl_in,
    input wire logic [63:0] strap_value_in,
    // Set-features request
    input wire logic set_req_in,
    input wire logic [63:0] set_value_in,
    input wire logic [63:0] set_rsvd_in,
    input wire logic apply_fail_in,
    // Feature query results
    output logic [63:0] features_avail_out,
    output logic [63:0] feature_status_out,
    output logic [63:0] feature_control_out,
    output logic set_done_out,
    output logic [7:0] set_status_out,
    // Bus-side events
    input wire logic data_err_in,
    input wire logic data_err_single_in,
    input wire logic addr_err_in,
    input wire logic addr_err_single_in,
    input wire logic prot_err_in,
    input wire logic prot_err_single_in,
    input wire logic bus_err_in,
    input wire logic own_req_err_in,
    input wire logic bus_error_pin_in,
    input wire logic resp_parity_err_in,
    input wire logic excl_evict_in,
    input wire logic shrd_evict_in,
    input wire logic lock_req_in,
    input wire logic txn_done_in,
    input wire logic last_owner_in,
    input wire logic others_pending_in,
    // Bus-side actions
    output logic data_correct_out,
    output logic bus_error_pin_out,
    output logic bus_init_pin_out,
    output logic corrected_check_interrupt_out,
    output logic machine_check_abort_out,
    output logic queue_single_out,
    output logic repl_txn_out,
    output logic half_rate_out,
    output logic lock_out,
    output logic bus_req_hold_out
);
    bfc_state_t state_ff;
    logic [63:0] status_ff;
    logic [63:0] ctrl_ff;
    logic [63:0] pend_ff;
    logic rst_seen_ff;
    logic [63:0] nxt_status;
    logic [63:0] ctrl_eff;
    logic [63:0] grp_set;
    logic [63:0] grp_clr;

    function automatic logic [63:0] legal(input logic [63:0] v);
        legal = v & BFC_DEFINED_MASK & AVAIL_MASK;
    endfunction

    assign ctrl_eff = legal(ctrl_ff);

    // Grouped members follow any member's change
    always_comb begin
        grp_set = 64'h0000_0000_0000_0000;
        grp_clr = 64'h0000_0000_0000_0000;
        if (|(pend_ff & ~status_ff & GROUP_MASK & ctrl_eff)) begin
            grp_set = GROUP_MASK & ctrl_eff;
        end
        if (|(~pend_ff & status_ff & GROUP_MASK & ctrl_eff)) begin
            grp_clr = GROUP_MASK & ctrl_eff;
        end
        nxt_status = (status_ff & ~ctrl_eff) | (pend_ff & ctrl_eff);
        nxt_status = (nxt_status | grp_set) & ~grp_clr;
        if (grp_set != 64'h0000_0000_0000_0000 && grp_clr != 64'h0000_0000_0000_0000) begin
            nxt_status = (status_ff & ~ctrl_eff) | (pend_ff & ctrl_eff & ~GROUP_MASK) | grp_set;
        end
        nxt_status = legal(nxt_status);
    end

    // Controllable set: parameter plus straps taken one cycle after release
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ctrl_ff <= BFC_CTRL_RST;
            rst_seen_ff <= 1'b1;
        end else begin
            rst_seen_ff <= 1'b0;
            if (rst_seen_ff) begin
                ctrl_ff <= CTRL_MASK | (strap_ctrl_in & ~CTRL_MASK);
            end
        end
    end

    // Set-features sequence
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_ff <= BFC_IDLE;
            status_ff <= BFC_STATUS_RST;
            pend_ff <= 64'h0000_0000_0000_0000;
            set_done_out <= 1'b0;
            set_status_out <= RC_OK;
        end else begin
            set_done_out <= 1'b0;
            if (rst_seen_ff) begin
                // Strap-controlled features load their strapped level
                status_ff <= legal(strap_value_in & strap_ctrl_in & ~CTRL_MASK);
            end
            unique case (state_ff)
                BFC_IDLE: begin
                    if (set_req_in) begin
                        if (set_rsvd_in != 64'h0000_0000_0000_0000) begin
                            set_status_out <= RC_INVALID;
                            set_done_out <= 1'b1;
                            state_ff <= BFC_DONE;
                        end else begin
                            pend_ff <= set_value_in;
                            state_ff <= BFC_APPLY;
                        end
                    end
                end
                BFC_APPLY: begin
                    if (apply_fail_in) begin
                        set_status_out <= RC_FAILED;
                    end else begin
                        status_ff <= nxt_status;
                        set_status_out <= RC_OK;
                    end
                    set_done_out <= 1'b1;
                    state_ff <= BFC_DONE;
                end
                BFC_DONE: begin
                    state_ff <= BFC_IDLE;
                end
            endcase
        end
    end

    // Query outputs
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            features_avail_out <= 64'h0000_0000_0000_0000;
            feature_status_out <= 64'h0000_0000_0000_0000;
            feature_control_out <= 64'h0000_0000_0000_0000;
        end else begin
            features_avail_out <= legal(64'hFFFF_FFFF_FFFF_FFFF);
            feature_status_out <= legal(status_ff);
            feature_control_out <= ctrl_eff;
        end
    end

    avail_out_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        !rst_seen_ff |=> features_avail_out == (BFC_DEFINED_MASK & AVAIL_MASK))
        else $error("implemented mask wrong");
    ctrl_keep_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        !rst_seen_ff |=> $stable(ctrl_ff))
        else $error("controllable set moved after reset");
    set_apply_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (state_ff == BFC_APPLY && !apply_fail_in)
        |=> ((status_ff ^ $past(pend_ff)) & ctrl_eff & ~GROUP_MASK) == 64'h0)
        else $error("controllable bit not written");
    grp_write_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (state_ff == BFC_APPLY && !apply_fail_in) |=> (status_ff & GROUP_MASK & ctrl_eff) == 64'h0
        || (status_ff & GROUP_MASK & ctrl_eff) == (GROUP_MASK & ctrl_eff))
        else $error("group members differ");
    ok_code_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (state_ff == BFC_APPLY && !apply_fail_in) |=> set_done_out && set_status_out == RC_OK)
        else $error("success not reported");

    // Error checking and signalling
    logic addr_chk, prot_chk, data_chk, errpin_sig, errpin_any;
    assign data_chk = ~status_ff[BIT_DATA_CHK_OFF];
    assign addr_chk = ~status_ff[BIT_ADDR_CHK_OFF];
    assign prot_chk = ~status_ff[BIT_PROT_CHK_OFF];
    assign errpin_sig = (addr_chk & addr_err_in & ~status_ff[BIT_ADDR_SIG_OFF])
        | (bus_err_in & ~status_ff[BIT_ERRPIN_SIG_OFF])
        | (own_req_err_in & ~status_ff[BIT_INTREQ_SIG_OFF]);
    assign errpin_any = bus_error_pin_in & ~status_ff[BIT_ERRPIN_IN_OFF];

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            data_correct_out <= 1'b0;
            bus_error_pin_out <= 1'b0;
            bus_init_pin_out <= 1'b0;
            corrected_check_interrupt_out <= 1'b0;
            machine_check_abort_out <= 1'b0;
        end else begin
            data_correct_out <= data_chk & data_err_in & data_err_single_in;
            bus_error_pin_out <= errpin_sig;
            bus_init_pin_out <= (prot_chk & prot_err_in & ~status_ff[BIT_PROT_SIG_OFF])
                | (resp_parity_err_in & ~status_ff[BIT_RESP_CHK_OFF]);
            corrected_check_interrupt_out <= (addr_chk & addr_err_in & addr_err_single_in)
                | (prot_chk & prot_err_in & prot_err_single_in);
            machine_check_abort_out <= (addr_chk & addr_err_in & ~addr_err_single_in)
                | (prot_chk & prot_err_in & ~prot_err_single_in) | errpin_any;
        end
    end

    data_fix_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (data_err_in && data_err_single_in && !status_ff[BIT_DATA_CHK_OFF]) |=> data_correct_out)
        else $error("single data error not corrected");
    data_off_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        status_ff[BIT_DATA_CHK_OFF] |=> !data_correct_out)
        else $error("data correction while disabled");
    addr_show_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (addr_err_in && !status_ff[BIT_ADDR_CHK_OFF] && !status_ff[BIT_ADDR_SIG_OFF]) |=> bus_error_pin_out)
        else $error("address error not signalled");
    addr_cci_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (addr_err_in && addr_err_single_in && !status_ff[BIT_ADDR_CHK_OFF]) |=> corrected_check_interrupt_out)
        else $error("single address error not reported");
    addr_abort_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (addr_err_in && !addr_err_single_in && !status_ff[BIT_ADDR_CHK_OFF]) |=> machine_check_abort_out)
        else $error("multi-bit address error not aborted");
    prot_cci_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (prot_err_in && prot_err_single_in && !status_ff[BIT_PROT_CHK_OFF]) |=> corrected_check_interrupt_out)
        else $error("single protocol error not reported");
    prot_sig_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (prot_err_in && !status_ff[BIT_PROT_CHK_OFF] && !status_ff[BIT_PROT_SIG_OFF]) |=> bus_init_pin_out)
        else $error("protocol error not signalled");
    prot_off_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (prot_err_in && !resp_parity_err_in && status_ff[BIT_PROT_CHK_OFF]) |=> !bus_init_pin_out)
        else $error("protocol error signalled with checking off");
    bus_err_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (bus_err_in && !status_ff[BIT_ERRPIN_SIG_OFF]) |=> bus_error_pin_out)
        else $error("bus error not signalled");
    own_err_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (own_req_err_in && !status_ff[BIT_INTREQ_SIG_OFF]) |=> bus_error_pin_out)
        else $error("own requester error not signalled");
    err_quiet_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (status_ff[BIT_ERRPIN_SIG_OFF] && status_ff[BIT_INTREQ_SIG_OFF] && !addr_err_in) |=> !bus_error_pin_out)
        else $error("error pin driven while disabled");
    pin_ignore_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (status_ff[BIT_ERRPIN_IN_OFF] && !addr_err_in && !prot_err_in) |=> !machine_check_abort_out)
        else $error("error pin not ignored");
    resp_init_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (resp_parity_err_in && !status_ff[BIT_RESP_CHK_OFF]) |=> bus_init_pin_out)
        else $error("response parity error not signalled");

    // Bus behaviour controls
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            queue_single_out <= 1'b0;
            repl_txn_out <= 1'b0;
            half_rate_out <= 1'b0;
            lock_out <= 1'b0;
            bus_req_hold_out <= 1'b0;
        end else begin
            queue_single_out <= status_ff[BIT_QUEUE_ONE];
            repl_txn_out <= (excl_evict_in & status_ff[BIT_EXCL_REPL])
                | (shrd_evict_in & status_ff[BIT_SHRD_REPL]);
            half_rate_out <= status_ff[BIT_HALF_RATE];
            lock_out <= lock_req_in & ~status_ff[BIT_LOCK_MASK];
            bus_req_hold_out <= txn_done_in & status_ff[BIT_PARK] & last_owner_in
                & ~others_pending_in;
        end
    end

    queue_one_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        ##1 queue_single_out == $past(status_ff[BIT_QUEUE_ONE]))
        else $error("queue depth select mismatch");
    repl_excl_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (excl_evict_in && status_ff[BIT_EXCL_REPL]) |=> repl_txn_out)
        else $error("exclusive replacement missing");
    repl_shrd_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (shrd_evict_in && status_ff[BIT_SHRD_REPL]) |=> repl_txn_out)
        else $error("shared replacement missing");
    repl_none_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (!status_ff[BIT_EXCL_REPL] && !status_ff[BIT_SHRD_REPL]) |=> !repl_txn_out)
        else $error("replacement while disabled");
    lock_pass_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (lock_req_in && !status_ff[BIT_LOCK_MASK]) |=> lock_out)
        else $error("atomic lock dropped");
    park_on_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (txn_done_in && last_owner_in && !others_pending_in && status_ff[BIT_PARK]) |=> bus_req_hold_out)
        else $error("parking request not held");

    // Checks
    ctrl_only_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (state_ff == BFC_APPLY && !rst_seen_ff) |=> ((status_ff ^ $past(status_ff)) & ~ctrl_eff) == 64'h0)
        else $error("non-controllable bit changed");
    rsvd_zero_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        ((features_avail_out | feature_status_out | feature_control_out) & ~BFC_DEFINED_MASK) == 64'h0)
        else $error("reserved bit nonzero");
    rst_zero_a: assert property (@(posedge mclk_in)
        $fell(srst_in) |-> ((status_ff & CTRL_MASK) == 64'h0))
        else $error("feature not zero after reset");
    inval_code_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (state_ff == BFC_IDLE && set_req_in && set_rsvd_in != 64'h0) |=> set_done_out && set_status_out == RC_INVALID)
        else $error("invalid argument not reported");
    fail_keep_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (state_ff == BFC_APPLY && apply_fail_in && !rst_seen_ff) |=> status_ff == $past(status_ff)
        && set_status_out == RC_FAILED)
        else $error("failed set changed state");
    addr_sig_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (addr_err_in && status_ff[BIT_ADDR_CHK_OFF] && !bus_err_in && !own_req_err_in) |=> !bus_error_pin_out)
        else $error("address error signalled with checking off");
    pin_abort_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (bus_error_pin_in && !status_ff[BIT_ERRPIN_IN_OFF]) |=> machine_check_abort_out)
        else $error("bus error pin missed");
    lock_mask_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        status_ff[BIT_LOCK_MASK] |=> !lock_out)
        else $error("lock not masked");
    park_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        (txn_done_in && !status_ff[BIT_PARK]) |=> !bus_req_hold_out)
        else $error("request held without parking");
    rate_a: assert property (@(posedge mclk_in) disable iff (srst_in)
        ##1 half_rate_out == $past(status_ff[BIT_HALF_RATE]))
        else $error("rate select mismatch");
    set_ok_c: cover property (@(posedge mclk_in) set_done_out && set_status_out == RC_OK);
    set_inv_c: cover property (@(posedge mclk_in) set_done_out && set_status_out == RC_INVALID);
    set_fail_c: cover property (@(posedge mclk_in) set_done_out && set_status_out == RC_FAILED);
    abort_c: cover property (@(posedge mclk_in) machine_check_abort_out);
    group_c: cover property (@(posedge mclk_in) state_ff == BFC_APPLY && (pend_ff & GROUP_MASK) != 64'h0);
endmodule

// ==== rtl/bfc_pkg.sv ====
// Constants and types for the bus feature configuration block
package bfc_pkg;
    localparam int BFC_W = 64;
    localparam int BIT_DATA_CHK_OFF = 63;
    localparam int BIT_ADDR_SIG_OFF = 62;
    localparam int BIT_ADDR_CHK_OFF = 61;
    localparam int BIT_PROT_SIG_OFF = 60;
    localparam int BIT_PROT_CHK_OFF = 59;
    localparam int BIT_ERRPIN_SIG_OFF = 58;
    localparam int BIT_INTREQ_SIG_OFF = 57;
    localparam int BIT_ERRPIN_IN_OFF = 56;
    localparam int BIT_RESP_CHK_OFF = 55;
    localparam int BIT_QUEUE_ONE = 54;
    localparam int BIT_EXCL_REPL = 53;
    localparam int BIT_SHRD_REPL = 52;
    localparam int BIT_HALF_RATE = 31;
    localparam int BIT_LOCK_MASK = 30;
    localparam int BIT_PARK = 29;
    // Defined feature positions; everything else is reserved
    localparam logic [63:0] BFC_DEFINED_MASK = 64'hFFF0_0000_E000_0000;
    // Default implemented and controllable sets: all defined bits
    localparam logic [63:0] BFC_AVAIL_RST = 64'hFFF0_0000_E000_0000;
    localparam logic [63:0] BFC_CTRL_RST = 64'hFFF0_0000_E000_0000;
    localparam logic [63:0] BFC_STATUS_RST = 64'h0000_0000_0000_0000;
    localparam logic [63:0] BFC_GROUPS_RST = 64'h0000_0000_0000_0000;
    localparam logic [1:0] ST_OK = 2'h0;
    localparam logic [1:0] ST_INVALID = 2'h2;
    localparam logic [1:0] ST_FAILED = 2'h3;
    localparam logic [7:0] RC_OK = 8'h00;
    localparam logic [7:0] RC_INVALID = 8'hFE;
    localparam logic [7:0] RC_FAILED = 8'hFD;
    typedef enum logic [2:0] {
        BFC_IDLE = 3'b001,
        BFC_APPLY = 3'b010,
        BFC_DONE = 3'b100
    } bfc_state_t;
endpackage

// ==== verif/bfc_bus_agent.sv ====
// Far-side bus agent model driving event lines
`timescale 1ns/1ps
module bfc_bus_agent (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // Event request and pacing
    input wire logic [15:0] ev_req_in,
    input wire logic slow_in,
    // Bus event lines
    output logic [15:0] ev_out
);
    logic [15:0] hold_ff;
    // Agent only raises bus events, never touches the feature vector
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            hold_ff <= '0;
            ev_out <= '0;
        end else begin
            hold_ff <= ev_req_in;
            // Slow agent shows the event one cycle late
            ev_out <= slow_in ? hold_ff : ev_req_in;
        end
    end
endmodule

// ==== verif/tb_bfc_bus_feature_config.sv ====
// Self-checking bench for the bus feature configuration block
`timescale 1ns/1ps
module tb_bfc_bus_feature_config;
    import bfc_pkg::*;
    localparam logic [63:0] B31 = 64'h0000_0000_8000_0000;
    localparam logic [63:0] CTL = BFC_CTRL_RST & ~B31;
    localparam logic [63:0] GRP = 64'h0030_0000_0000_0000;
    logic mclk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [63:0] strap_c = '0;
    logic [63:0] strap_v = '0;
    logic [63:0] set_v = '0;
    logic [63:0] set_r = '0;
    logic set_req = 1'b0;
    logic fail = 1'b0;
    logic slow = 1'b0;
    logic [15:0] ev_req = '0;
    logic [15:0] ev;
    logic [63:0] avail, stat, ctrl, cur, exp_ctl;
    logic done;
    logic [7:0] rc;
    wire logic [9:0] act;
    int bad_count = 0;
    int n_checks = 0;

    bfc_bus_feature_config #(.CTRL_MASK(CTL), .GROUP_MASK(GRP)) DUT (
        .mclk_in(mclk_in), .srst_in(srst_in), .strap_ctrl_in(strap_c), .strap_value_in(strap_v),
        .set_req_in(set_req), .set_value_in(set_v), .set_rsvd_in(set_r), .apply_fail_in(fail),
        .features_avail_out(avail), .feature_status_out(stat), .feature_control_out(ctrl),
        .set_done_out(done), .set_status_out(rc),
        .data_err_in(ev[0]), .data_err_single_in(ev[1]), .addr_err_in(ev[2]),
        .addr_err_single_in(ev[3]), .prot_err_in(ev[4]), .prot_err_single_in(ev[5]),
        .bus_err_in(ev[6]), .own_req_err_in(ev[7]), .bus_error_pin_in(ev[8]),
        .resp_parity_err_in(ev[9]), .excl_evict_in(ev[10]), .shrd_evict_in(ev[11]),
        .lock_req_in(ev[12]), .txn_done_in(ev[13]), .last_owner_in(ev[14]), .others_pending_in(ev[15]),
        .data_correct_out(act[0]), .bus_error_pin_out(act[1]), .bus_init_pin_out(act[2]),
        .corrected_check_interrupt_out(act[3]), .machine_check_abort_out(act[4]),
        .queue_single_out(act[5]), .repl_txn_out(act[6]), .half_rate_out(act[7]),
        .lock_out(act[8]), .bus_req_hold_out(act[9]));

    bfc_bus_agent AGENT (.mclk_in(mclk_in), .srst_in(srst_in), .ev_req_in(ev_req), .slow_in(slow), .ev_out(ev));

    initial begin
        forever #4 mclk_in = ~mclk_in;
    end

    task automatic end_of_test;
        $display("Checks %0d, errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] expv);
        n_checks++;
        if (seen !== expv) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    // Group members move together; a set wins from an all-clear group
    function automatic logic [63:0] nxt_feat(input logic [63:0] c, input logic [63:0] v, input logic [63:0] k);
        logic [63:0] r;
        r = (c & ~k) | (v & k);
        if ((c & GRP) == '0) r = ((v & GRP & k) != '0) ? (r | GRP) : (r & ~GRP);
        else r = ((~v & GRP & k) != '0) ? (r & ~GRP) : (r | GRP);
        return r & BFC_DEFINED_MASK;
    endfunction

    task automatic do_set(input logic [63:0] v, input logic [63:0] r, input logic f);
        int n;
        n = 0;
        @(posedge mclk_in);
        set_req <= 1'b1;
        set_v <= v;
        set_r <= r;
        fail <= f;
        do begin
            @(posedge mclk_in);
            set_req <= 1'b0;
            #1;
            n++;
        end while (done !== 1'b1 && n < 5);
        check(64'(n), (r != '0) ? 64'd1 : 64'd2);
        check(rc, (r != '0) ? RC_INVALID : (f ? RC_FAILED : RC_OK));
        if (r == '0 && !f) cur = nxt_feat(cur, v, exp_ctl);
        @(posedge mclk_in);
        fail <= 1'b0;
        #1;
        check(done, 1'b0);
        check(stat, cur);
    endtask

    task automatic ev_run(input logic [15:0] e, input logic [9:0] m, input logic want, input logic s);
        @(posedge mclk_in);
        slow <= s;
        ev_req <= e;
        @(posedge mclk_in);
        ev_req <= '0;
        repeat (s ? 2 : 1) @(posedge mclk_in);
        #1;
        check(|(act & m), want);
    endtask

    // Each feature bit tried clear then set, prompt then slow agent
    task automatic feat(input int b, input logic [15:0] e, input logic [9:0] m, input logic on_set);
        for (int k = 0; k < 2; k++) begin
            do_set(k ? (64'h1 << b) : 64'h0, '0, 1'b0);
            ev_run(e, m, k[0] == on_set, k[0]);
        end
    endtask

    task automatic do_reset;
        @(posedge mclk_in);
        srst_in <= 1'b1;
        repeat (8) @(posedge mclk_in);
        srst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_in);
        bad_count++;
        end_of_test;
    end

    initial begin
        void'($urandom(67743));
        do_reset;
        cur = '0;
        exp_ctl = CTL;
        check(avail, BFC_AVAIL_RST);
        check(ctrl, CTL);
        check(stat, 64'h0);
        do_set(64'hFFFF_FFFF_FFFF_FFFF, '0, 1'b0);
        do_set({$urandom, $urandom}, 64'h1, 1'b0);
        do_set({$urandom, $urandom}, '0, 1'b1);
        // Straps make the optional rate bit controllable and preset it
        strap_c <= B31;
        strap_v <= B31;
        do_reset;
        cur = B31;
        exp_ctl = CTL | B31;
        check(ctrl, CTL | B31);
        check(stat, B31);
        repeat (20) do_set({$urandom, $urandom}, '0, 1'b0);
        feat(63, 16'h0003, 10'h001, 1'b0);
        feat(62, 16'h0004, 10'h006, 1'b0);
        feat(61, 16'h000C, 10'h008, 1'b0);
        feat(60, 16'h0010, 10'h006, 1'b0);
        feat(59, 16'h0030, 10'h008, 1'b0);
        feat(58, 16'h0040, 10'h002, 1'b0);
        feat(57, 16'h0080, 10'h002, 1'b0);
        feat(56, 16'h0100, 10'h010, 1'b0);
        feat(55, 16'h0200, 10'h004, 1'b0);
        feat(54, 16'h0000, 10'h020, 1'b1);
        feat(53, 16'h0400, 10'h040, 1'b1);
        feat(52, 16'h0800, 10'h040, 1'b1);
        feat(31, 16'h0000, 10'h080, 1'b1);
        feat(30, 16'h1000, 10'h100, 1'b0);
        feat(29, 16'h6000, 10'h200, 1'b1);
        end_of_test;
    end
endmodule
